// File: include/asco_pkg.sv
`default_nettype none
package asco_pkg;
  // Instruction word width and field positions
  localparam int IW_W        = 14;   // Instruction word width
  localparam int FADDR_W     = 7;    // File register address field width
  localparam int BITSEL_LSB  = 7;    // Bit-select field low bit
  localparam int BITSEL_W    = 3;    // Bit-select field width
  localparam int DEST_BIT    = 7;    // Destination select bit
  localparam int PC_W        = 13;   // Program counter width
  localparam int CALL_K_W    = 11;   // Call target field width
  localparam int PAGE_LO     = 3;    // Page select low bit
  localparam int PAGE_HI     = 4;    // Page select high bit
  localparam int DOG_W       = 8;    // Watchdog counter width
  localparam int PRE_W       = 8;    // Watchdog prescaler width
  // Opcode patterns
  localparam logic [13:0] OPC_AND_LIT_M  = 14'h3F00;  // Mask for literal AND
  localparam logic [13:0] OPC_AND_LIT_V  = 14'h3900;
  localparam logic [13:0] OPC_AND_FILE_M = 14'h3F00;  // Mask for file AND
  localparam logic [13:0] OPC_AND_FILE_V = 14'h0500;
  localparam logic [13:0] OPC_BIT_TEST_M = 14'h3C00;  // Mask for bit tests
  localparam logic [13:0] OPC_SKIP_CLR_V = 14'h1800;
  localparam logic [13:0] OPC_SKIP_SET_V = 14'h1C00;
  localparam logic [13:0] OPC_CALL_M     = 14'h3800;  // Mask for call
  localparam logic [13:0] OPC_CALL_V     = 14'h2000;
  localparam logic [13:0] OPC_CLR_FILE_M = 14'h3F80;  // Mask for file clear
  localparam logic [13:0] OPC_CLR_FILE_V = 14'h0180;
  localparam logic [13:0] OPC_CLR_ACC_M  = 14'h3F80;  // Mask for acc clear
  localparam logic [13:0] OPC_CLR_ACC_V  = 14'h0100;
  localparam logic [13:0] OPC_CLR_DOG    = 14'h0064;  // Exact watchdog clear
  // Reset values
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [12:0] PC_RST       = 13'h0000;
  localparam logic [7:0]  ZERO8        = 8'h00;
  // Watchdog wrap point
  localparam logic [7:0]  DOG_TOP      = 8'hFF;  // Last value of prescaler and counter
  // Decoded operation kinds
  typedef enum logic [2:0] {
    OP_NONE, OP_AND_LIT, OP_AND_FILE, OP_SKIP_CLR, OP_SKIP_SET, OP_CALL, OP_CLR_FILE, OP_CLR_ACC
  } asco_op_t;
endpackage
`default_nettype wire

// File: include/asco_dec_if.sv
`default_nettype none
// Decoded instruction fields from decoder to execution
interface asco_dec_if;
  asco_pkg::asco_op_t  op;        // Operation kind
  logic                dog_clr;   // Watchdog clear operation
  logic [7:0]          lit;       // Literal operand
  logic [6:0]          faddr;     // File address
  logic [2:0]          bitsel;    // Bit select
  logic                dest;      // Destination bit
  logic [10:0]         target;    // Call target
  modport dec (output op, dog_clr, lit, faddr, bitsel, dest, target);
  modport exe (input  op, dog_clr, lit, faddr, bitsel, dest, target);
endinterface
`default_nettype wire

// File: rtl/asco_decode.sv
`default_nettype none
// Splits an instruction word into operation kind and operand fields
module asco_decode (
  input  wire logic [13:0] instr,
  asco_dec_if.dec          d
);
  // Operation classification
  always_comb begin
    if ((instr & asco_pkg::OPC_AND_LIT_M) == asco_pkg::OPC_AND_LIT_V) begin
      d.op = asco_pkg::OP_AND_LIT;
    end else if ((instr & asco_pkg::OPC_AND_FILE_M) == asco_pkg::OPC_AND_FILE_V) begin
      d.op = asco_pkg::OP_AND_FILE;
    end else if ((instr & asco_pkg::OPC_BIT_TEST_M) == asco_pkg::OPC_SKIP_CLR_V) begin
      d.op = asco_pkg::OP_SKIP_CLR;
    end else if ((instr & asco_pkg::OPC_BIT_TEST_M) == asco_pkg::OPC_SKIP_SET_V) begin
      d.op = asco_pkg::OP_SKIP_SET;
    end else if ((instr & asco_pkg::OPC_CALL_M) == asco_pkg::OPC_CALL_V) begin
      d.op = asco_pkg::OP_CALL;
    end else if ((instr & asco_pkg::OPC_CLR_FILE_M) == asco_pkg::OPC_CLR_FILE_V) begin
      d.op = asco_pkg::OP_CLR_FILE;
    end else if ((instr & asco_pkg::OPC_CLR_ACC_M) == asco_pkg::OPC_CLR_ACC_V) begin
      d.op = asco_pkg::OP_CLR_ACC;
    end else begin
      d.op = asco_pkg::OP_NONE;
    end
  end
  // Operand fields
  assign d.dog_clr = (instr == asco_pkg::OPC_CLR_DOG);
  assign d.lit     = instr[7:0];
  assign d.faddr   = instr[asco_pkg::FADDR_W-1:0];
  assign d.bitsel  = instr[asco_pkg::BITSEL_LSB +: asco_pkg::BITSEL_W];
  assign d.dest    = instr[asco_pkg::DEST_BIT];
  assign d.target  = instr[asco_pkg::CALL_K_W-1:0];
endmodule // asco_decode
`default_nettype wire

// File: rtl/asco_exec.sv
// Notes on behaviour
// - Literal AND into accumulator, zero flag updated
// - Bit set skips next, two cycles
// - Bit clear skips next, two cycles
// - File AND, dest bit picks target
// - Call pushes incremented program counter in the same cycle as the PC load
// - Call loads eleven-bit target into low bits
// - Page latch bits 4:3 give PC 12:11
// - Call always takes two cycles
// - File clear writes zero, sets zero flag
// - Accumulator clear writes zero, sets zero flag
// - Watchdog clear zeroes counter and prescaler
// - Watchdog clear sets expiry and sleep flags
// - PC change or true test: second cycle NOP
`default_nettype none
module asco_exec (
  input  wire logic        SYS_CLK,         // Instruction clock
  input  wire logic        RESETN,          // Asynchronous reset, active low
  input  wire logic        INSTR_VALID,     // Instruction present this cycle
  input  wire logic [13:0] INSTR,           // Instruction word
  input  wire logic [12:0] PC_IN,           // Address of current instruction
  input  wire logic [7:0]  PAGE_SELECT_LATCH, // Page select register
  input  wire logic [7:0]  FILE_RDATA,      // Data of addressed file register
  input  wire logic        DOG_TICK,        // Watchdog prescaler input pulse
  output logic [7:0]       ACC_REGISTER,    // Accumulator
  output logic             RESULT_NULL_FLAG, // Zero flag
  output logic [6:0]       FILE_ADDR,       // File register address
  output logic [7:0]       FILE_WDATA,      // File register write data
  output logic             FILE_WE,         // File register write pulse
  output logic [12:0]      STACK_HEAD,      // Value pushed to stack
  output logic             STACK_PUSH,      // Stack push pulse
  output logic [12:0]      PC_LOAD,         // New program counter
  output logic             PC_LOAD_EN,      // Program counter load pulse
  output logic             SLOT_NOP,        // Previous cycle executed as NOP
  output logic [7:0]       DOG_TIMER_COUNT, // Watchdog counter
  output logic             DOG_TIMER_EXPIRY_FLAG, // Active-low style flag, 1 = no timeout
  output logic             SLEEP_ENTRY_FLAG // Active-low style flag, 1 = no sleep
);
  logic                    rst_s1_q;   // Reset release stage one
  logic                    rstn_q;     // Synchronised reset
  logic                    nop_q;      // Second cycle pending as NOP
  logic [7:0]              pre_q;      // Watchdog prescaler
  logic [7:0]              and_res;    // AND result
  logic                    bit_val;    // Tested bit
  logic                    go;         // Instruction executes this cycle
  asco_dec_if              dx ();      // Decoded fields

  // Decoder instance
  asco_decode u_dec (
    .instr (INSTR),
    .d     (dx.dec)
  );

  // Reset release through two flops
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_q <= 1'b0;
      rstn_q   <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rstn_q   <= rst_s1_q;
    end
  end

  // An instruction executes unless its slot is a forced NOP
  assign go      = INSTR_VALID && !nop_q;
  // Accumulator AND with literal or file operand
  assign and_res = ACC_REGISTER & ((dx.op == asco_pkg::OP_AND_LIT) ? dx.lit : FILE_RDATA);
  // One of eight bits chosen by the three-bit field
  assign bit_val = FILE_RDATA[dx.bitsel];

  // Second-cycle NOP after PC change or true skip test
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      nop_q <= 1'b0;
    end else if (nop_q) begin
      nop_q <= 1'b0;
    end else if (go) begin
      nop_q <= (dx.op == asco_pkg::OP_CALL)
            || (dx.op == asco_pkg::OP_SKIP_SET && bit_val)
            || (dx.op == asco_pkg::OP_SKIP_CLR && !bit_val);
    end
  end
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      SLOT_NOP <= 1'b0;
    end else begin
      SLOT_NOP <= nop_q;
    end
  end

  // Accumulator update
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      ACC_REGISTER <= asco_pkg::ACC_RST;
    end else if (go) begin
      case (dx.op)
        asco_pkg::OP_AND_LIT: ACC_REGISTER <= and_res;
        asco_pkg::OP_AND_FILE: begin
          if (!dx.dest) begin
            ACC_REGISTER <= and_res;
          end
        end
        asco_pkg::OP_CLR_ACC: ACC_REGISTER <= asco_pkg::ZERO8;
        default:            ACC_REGISTER <= ACC_REGISTER;
      endcase
    end
  end

  // Zero flag
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      RESULT_NULL_FLAG <= 1'b0;
    end else if (go) begin
      case (dx.op)
        asco_pkg::OP_AND_LIT,
        asco_pkg::OP_AND_FILE: RESULT_NULL_FLAG <= (and_res == asco_pkg::ZERO8);
        asco_pkg::OP_CLR_FILE: RESULT_NULL_FLAG <= 1'b1;
        asco_pkg::OP_CLR_ACC:  RESULT_NULL_FLAG <= 1'b1;
        default:            RESULT_NULL_FLAG <= RESULT_NULL_FLAG;
      endcase
    end
  end

  // File register write port
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      FILE_WE    <= 1'b0;
      FILE_ADDR  <= 7'h00;
      FILE_WDATA <= asco_pkg::ZERO8;
    end else begin
      FILE_ADDR <= dx.faddr;
      if (go && dx.op == asco_pkg::OP_AND_FILE && dx.dest) begin
        FILE_WE    <= 1'b1;
        FILE_WDATA <= and_res;
      end else if (go && dx.op == asco_pkg::OP_CLR_FILE) begin
        FILE_WE    <= 1'b1;
        FILE_WDATA <= asco_pkg::ZERO8;
      end else begin
        FILE_WE    <= 1'b0;
      end
    end
  end

  // Call: push return address and load paged target
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      STACK_PUSH <= 1'b0;
      STACK_HEAD <= asco_pkg::PC_RST;
      PC_LOAD_EN <= 1'b0;
      PC_LOAD    <= asco_pkg::PC_RST;
    end else if (go && dx.op == asco_pkg::OP_CALL) begin
      STACK_PUSH <= 1'b1;
      STACK_HEAD <= PC_IN + 13'h0001;
      PC_LOAD_EN <= 1'b1;
      PC_LOAD    <= {PAGE_SELECT_LATCH[asco_pkg::PAGE_HI:asco_pkg::PAGE_LO], dx.target};
    end else begin
      STACK_PUSH <= 1'b0;
      PC_LOAD_EN <= 1'b0;
    end
  end

  // Watchdog prescaler and counter
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      pre_q           <= asco_pkg::ZERO8;
      DOG_TIMER_COUNT <= asco_pkg::ZERO8;
    end else if (go && dx.dog_clr) begin
      pre_q           <= asco_pkg::ZERO8;
      DOG_TIMER_COUNT <= asco_pkg::ZERO8;
    end else if (DOG_TICK) begin
      pre_q <= pre_q + 8'h01;
      if (pre_q == asco_pkg::DOG_TOP) begin
        DOG_TIMER_COUNT <= DOG_TIMER_COUNT + 8'h01;
      end
    end
  end

  // Expiry and sleep status flags
  always_ff @(posedge SYS_CLK or negedge rstn_q) begin
    if (!rstn_q) begin
      DOG_TIMER_EXPIRY_FLAG <= 1'b1;
      SLEEP_ENTRY_FLAG      <= 1'b1;
    end else if (go && dx.dog_clr) begin
      DOG_TIMER_EXPIRY_FLAG <= 1'b1;
      SLEEP_ENTRY_FLAG      <= 1'b1;
    end else if (DOG_TICK && pre_q == asco_pkg::DOG_TOP && DOG_TIMER_COUNT == asco_pkg::DOG_TOP) begin
      DOG_TIMER_EXPIRY_FLAG <= 1'b0;
    end
  end

  // Call always leaves a NOP second cycle
  call_two_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.op == asco_pkg::OP_CALL |=> nop_q ##1 !nop_q)
    else $error("call not two cycles");
  // Skip decisions follow the tested bit
  skip_set_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.op == asco_pkg::OP_SKIP_SET |=> nop_q == $past(bit_val))
    else $error("set skip wrong");
  skip_clr_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.op == asco_pkg::OP_SKIP_CLR |=> nop_q == !$past(bit_val))
    else $error("clear skip wrong");
  // Return address and paged target
  push_addr_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    STACK_PUSH |-> STACK_HEAD == $past(PC_IN) + 13'h0001)
    else $error("bad return addr");
  call_tgt_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    PC_LOAD_EN |-> PC_LOAD[10:0] == $past(INSTR[10:0])
      && PC_LOAD[12:11] == $past(PAGE_SELECT_LATCH[4:3]))
    else $error("bad call target");
  // Accumulator and file results
  and_lit_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.op == asco_pkg::OP_AND_LIT |=> ACC_REGISTER == ($past(ACC_REGISTER) & $past(INSTR[7:0]))
      && RESULT_NULL_FLAG == (ACC_REGISTER == 8'h00))
    else $error("literal AND wrong");
  and_file_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.op == asco_pkg::OP_AND_FILE && dx.dest |=> FILE_WE
      && FILE_WDATA == ($past(ACC_REGISTER) & $past(FILE_RDATA))
      && RESULT_NULL_FLAG == (FILE_WDATA == 8'h00))
    else $error("file AND wrong");
  clr_acc_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.op == asco_pkg::OP_CLR_ACC |=> ACC_REGISTER == 8'h00 && RESULT_NULL_FLAG)
    else $error("acc clear wrong");
  clr_file_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.op == asco_pkg::OP_CLR_FILE |=> FILE_WE && FILE_WDATA == 8'h00 && RESULT_NULL_FLAG)
    else $error("file clear wrong");
  // Suppressed slot has no side effects
  nop_slot_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    nop_q |=> SLOT_NOP && !FILE_WE && !STACK_PUSH && !PC_LOAD_EN)
    else $error("nop slot not idle");
  // Watchdog clear zeroes counts and raises both flags
  dog_clr_a: assert property (@(posedge SYS_CLK) disable iff (!rstn_q)
    go && dx.dog_clr |=> DOG_TIMER_COUNT == 8'h00 && pre_q == 8'h00
      && DOG_TIMER_EXPIRY_FLAG && SLEEP_ENTRY_FLAG)
    else $error("watchdog clear wrong");
endmodule // asco_exec
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk           = 1'b0;      // Instruction clock
  logic        resetn            = 1'b0;      // Reset, active low
  logic        instr_valid       = 1'b0;      // Instruction present
  logic [13:0] instr             = 14'h0000;  // Instruction word
  logic [12:0] pc_in             = 13'h0000;  // Address of instruction
  logic [7:0]  page_select_latch = 8'h00;     // Page register
  logic [7:0]  file_rdata        = 8'h00;     // Addressed file contents
  logic        dog_tick          = 1'b0;      // Prescaler input
  logic [7:0]  acc, fwdata, dog;              // Accumulator, write data, watchdog count
  logic [12:0] head, pcl;                     // Pushed value, new program counter
  logic [6:0]  faddr;                         // File address
  logic        zf, fwe, push, pcl_en, nop_s, expf, slpf; // Flags and pulses
  int          errors, samples_checked, cycles;          // Counters
  logic [10:0] ks[3]  = '{11'h7FF, 11'h000, 11'h555};    // Call targets
  logic [7:0]  pls[3] = '{8'h10, 8'hE7, 8'h18};          // Page register values
  logic [12:0] pcs[3] = '{13'h0ABC, 13'h1FFF, 13'h0000}; // Call addresses
  logic [13:0] ops[4] = '{14'h39FF, 14'h05C5, 14'h01C5, 14'h0100}; // Two ANDs, two clears
  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;
  asco_exec dut (.SYS_CLK(sys_clk), .RESETN(resetn), .INSTR_VALID(instr_valid), .INSTR(instr),
    .PC_IN(pc_in), .PAGE_SELECT_LATCH(page_select_latch), .FILE_RDATA(file_rdata), .DOG_TICK(dog_tick),
    .ACC_REGISTER(acc), .RESULT_NULL_FLAG(zf), .FILE_ADDR(faddr), .FILE_WDATA(fwdata), .FILE_WE(fwe),
    .STACK_HEAD(head), .STACK_PUSH(push), .PC_LOAD(pcl), .PC_LOAD_EN(pcl_en), .SLOT_NOP(nop_s),
    .DOG_TIMER_COUNT(dog), .DOG_TIMER_EXPIRY_FLAG(expf), .SLEEP_ENTRY_FLAG(slpf));
  // Prints counts and verdict, then stops
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("CHECK FAILED at %0t ns: run too long", $time);
      final_report();
    end
  end
  // Compares one value
  task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Presents one instruction and lets its taking edge pass
  task automatic run(input logic [13:0] op, input logic [7:0] rd, input logic [12:0] pc = 13'h0000);
    instr = op;
    file_rdata = rd;
    pc_in = pc;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask
  // Idle cycles with no instruction
  task automatic idle(input int n);
    instr_valid = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Holds reset for six cycles, waits until instructions are allowed
  task automatic do_reset();
    resetn = 1'b0;
    instr_valid = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Feeds n back-to-back prescaler pulses, then one quiet edge
  task automatic ticks(input int n);
    dog_tick = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
    dog_tick = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // Main sequence
  initial begin
    logic [7:0] rd;
    logic       tk;
    do_reset();
    chk(expf, 1'b1, "expiry flag at reset");
    chk(slpf, 1'b1, "sleep flag at reset");
    // Each AND or clear from a fresh reset, zero flag starting low
    for (int i = 0; i < 4; i++) begin
      do_reset();
      chk(zf, 1'b0, "zero flag at reset");
      run(ops[i], 8'hFF);
      chk(zf, 1'b1, "zero flag after op");
      chk(acc, 8'h00, "accumulator");
      chk(fwe, (i == 1 || i == 2), "file write pulse");
      chk(fwdata, 8'h00, "file write data");
      if (i == 1 || i == 2) chk(faddr, 7'h45, "file address");
      idle(1);
    end
    run(14'h0545, 8'hFF);
    chk(fwe, 1'b0, "and to accumulator keeps file");
    // Bit tests on every bit position, both kinds, both outcomes
    for (int s = 0; s < 2; s++) begin
      for (int b = 0; b < 8; b++) begin
        for (int t = 0; t < 2; t++) begin
          tk = t[0];
          rd = ((s == 1) == tk) ? (8'h01 << b) : ~(8'h01 << b);
          run(14'h1815 | (14'(s) << 10) | (14'(b) << 7), rd);
          chk(fwe, 1'b0, "test writes nothing");
          run(14'h01A2, 8'h00);
          chk(fwe, !tk, "instruction after test");
          chk(nop_s, tk, "nop slot after test");
        end
      end
    end
    // Calls: push, target, page bits, two cycles
    for (int i = 0; i < 3; i++) begin
      page_select_latch = pls[i];
      run(14'h2000 | 14'(ks[i]), 8'h00, pcs[i]);
      chk(push, 1'b1, "push pulse");
      chk(head, pcs[i] + 13'h0001, "pushed address");
      chk(pcl_en, 1'b1, "load pulse");
      chk(pcl, {pls[i][4:3], ks[i]}, "call target");
      run(14'h01A2, 8'h00);
      chk(fwe, 1'b0, "second call cycle");
      chk(nop_s, 1'b1, "nop slot after call");
      chk(push, 1'b0, "push lasts one cycle");
      chk(pcl_en, 1'b0, "load lasts one cycle");
      run(14'h01A2, 8'h00);
      chk(fwe, 1'b1, "third cycle runs");
    end
    // Watchdog clear zeroes count and prescaler
    do_reset();
    ticks(300);
    chk(dog, 8'h01, "count after 300 pulses");
    run(14'h0064, 8'h00);
    chk(dog, 8'h00, "count cleared");
    idle(1);
    ticks(255);
    chk(dog, 8'h00, "prescaler was cleared");
    ticks(1);
    chk(dog, 8'h01, "count after 256 pulses");
    ticks(65280);
    chk(expf, 1'b0, "expiry after overflow");
    run(14'h0064, 8'h00);
    chk(expf, 1'b1, "expiry flag set");
    chk(slpf, 1'b1, "sleep flag set");
    chk(dog, 8'h00, "count after clear");
    idle(2);
    final_report();
  end
endmodule // testbench
`default_nettype wire
